// ---- logic/acs_pkg.sv ----
// shared constants and types for the accelerometer configuration sequencer
package acs_pkg;

    // device register offsets
    localparam logic [7:0] ACT_THRESH_LOW_ADDR   = 8'h20;
    localparam logic [7:0] ACT_THRESH_HIGH_ADDR  = 8'h21;
    localparam logic [7:0] ACT_DURATION_ADDR     = 8'h22;
    localparam logic [7:0] STILL_THRESH_LOW_ADDR = 8'h23;
    localparam logic [7:0] STILL_THRESH_UP_ADDR  = 8'h24;
    localparam logic [7:0] STILL_TIME_LOW_ADDR   = 8'h25;
    localparam logic [7:0] STILL_TIME_UP_ADDR    = 8'h26;
    localparam logic [7:0] MOTION_CTRL_ADDR      = 8'h27;
    localparam logic [7:0] QUEUE_CTRL_ADDR       = 8'h28;
    localparam logic [7:0] QUEUE_COUNT_ADDR      = 8'h29;
    localparam logic [7:0] IRQ_PIN1_MAP_ADDR     = 8'h2a;
    localparam logic [7:0] IRQ_PIN2_MAP_ADDR     = 8'h2b;
    localparam logic [7:0] GENERAL_ADDR          = 8'h2c;
    localparam logic [7:0] POWER_CTRL_ADDR       = 8'h2d;

    // field positions and values
    localparam int         RUN_STATE_LSB         = 0;
    localparam logic [1:0] RUN_STATE_RUN_STATE_FIELD     = 2'h2;
    localparam int         EXT_CLK_BIT           = 6;
    localparam int         EXT_TRIG_BIT          = 3;
    localparam logic [7:0] PWR_RUN_STATE_FIELD_VAL       = 8'h02;
    localparam logic [7:0] PWR_EXT_CLK_VAL       = 8'h42;
    localparam logic [7:0] MOTION_LOOP_VAL       = 8'h3f;
    localparam logic [7:0] MOTION_ABS_STILL_VAL  = 8'h04;
    localparam logic [7:0] MAP_DATA_READY_VAL    = 8'h01;
    localparam logic [7:0] MAP_STILL_VAL         = 8'h20;
    localparam logic [7:0] MAP_AWAKE_VAL         = 8'h40;
    localparam logic [7:0] GEN_8G_100HZ_VAL      = 8'h83;
    localparam logic [7:0] RATE_TRIG_4G_VAL      = 8'h6b;
    localparam logic [7:0] ACT_DURATION_VAL      = 8'h02;
    localparam logic [7:0] FALL_TIME_UP_VAL      = 8'h03;

    // timing
    localparam int         CLK_PERIOD_PS         = 5000;
    localparam int         SETTLE_MS             = 100;
    localparam int         SETTLE_CYCLES         = SETTLE_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int         EXT_CLK_HALF_CYCLES   = 8;
    localparam int         TRIG_HIGH_CYCLES      = 4;

    // sequence table entry: {last, settle, addr, data}
    localparam int         ENTRY_W               = 18;
    localparam int         STEP_W                = 4;

    typedef enum logic [1:0] {
        PROF_MOTION,
        PROF_FREEFALL,
        PROF_EXTCLK,
        PROF_EXTTRIG
    } acs_profile_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_SETTLE,
        ST_RUN
    } acs_state_t;

endpackage

// ---- logic/acs_pin_sync.sv ----
// two-flop synchroniser for a device pin with rising-edge pulse
`timescale 1ns/1ps
module acs_pin_sync import acs_pkg::*; (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edge taken from the second and third stages only
    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
endmodule // acs_pin_sync

// ---- logic/acs_seq_rom.sv ----
// write sequences for each start-up profile, in register-map order up to the power control write
`timescale 1ns/1ps
module acs_seq_rom import acs_pkg::*; (
    input  wire acs_profile_t      profile,
    input  wire logic              stillOnSecond,
    input  wire logic [STEP_W-1:0] step,
    output logic [ENTRY_W-1:0]     entry
);
    function automatic logic [ENTRY_W-1:0] ent(input logic last, input logic settle,
                                               input logic [7:0] a, input logic [7:0] d);
        return {last, settle, a, d};
    endfunction

    always_comb begin
        entry = ent(1'b1, 1'b0, POWER_CTRL_ADDR, PWR_RUN_STATE_FIELD_VAL);
        unique case (profile)
            PROF_MOTION: begin
                unique case (step)
                    // provisional thresholds force both events right after start
                    4'h0: entry = ent(1'b0, 1'b0, ACT_THRESH_LOW_ADDR, 8'ha0); // R10
                    4'h1: entry = ent(1'b0, 1'b0, ACT_THRESH_HIGH_ADDR, 8'h0f);
                    4'h2: entry = ent(1'b0, 1'b0, ACT_DURATION_ADDR, ACT_DURATION_VAL); // R3
                    4'h3: entry = ent(1'b0, 1'b0, STILL_THRESH_LOW_ADDR, 8'h60);
                    4'h4: entry = ent(1'b0, 1'b0, STILL_THRESH_UP_ADDR, 8'h09);
                    4'h5: entry = ent(1'b0, 1'b0, MOTION_CTRL_ADDR, MOTION_LOOP_VAL);
                    4'h6: entry = ent(1'b0, 1'b0, IRQ_PIN1_MAP_ADDR, MAP_DATA_READY_VAL);
                    4'h7: entry = ent(1'b0, 1'b0, IRQ_PIN2_MAP_ADDR, MAP_AWAKE_VAL);
                    4'h8: entry = ent(1'b0, 1'b1, POWER_CTRL_ADDR, PWR_RUN_STATE_FIELD_VAL); // R2
                    4'h9: entry = ent(1'b0, 1'b0, ACT_THRESH_LOW_ADDR, 8'h0f); // R10
                    4'ha: entry = ent(1'b0, 1'b0, ACT_THRESH_HIGH_ADDR, 8'ha0);
                    4'hb: entry = ent(1'b0, 1'b0, STILL_THRESH_LOW_ADDR, 8'h0a);
                    default: entry = ent(1'b1, 1'b0, STILL_THRESH_UP_ADDR, 8'hf0);
                endcase
            end
            PROF_FREEFALL: begin
                unique case (step)
                    4'h0: entry = ent(1'b0, 1'b0, STILL_THRESH_LOW_ADDR, 8'h09); // R17
                    4'h1: entry = ent(1'b0, 1'b0, STILL_THRESH_UP_ADDR, 8'h18);
                    4'h2: entry = ent(1'b0, 1'b0, STILL_TIME_UP_ADDR, FALL_TIME_UP_VAL); // R16 R18
                    4'h3: entry = ent(1'b0, 1'b0, MOTION_CTRL_ADDR, MOTION_ABS_STILL_VAL);
                    4'h4: entry = ent(1'b0, 1'b0,
                                      stillOnSecond ? IRQ_PIN2_MAP_ADDR : IRQ_PIN1_MAP_ADDR,
                                      MAP_STILL_VAL);
                    4'h5: entry = ent(1'b0, 1'b0, GENERAL_ADDR, GEN_8G_100HZ_VAL);
                    default: entry = ent(1'b1, 1'b1, POWER_CTRL_ADDR, PWR_RUN_STATE_FIELD_VAL); // R2
                endcase
            end
            PROF_EXTCLK: begin
                // clock switch is legal only in standby, so start this profile after reset
                entry = ent(1'b1, 1'b1, POWER_CTRL_ADDR, PWR_EXT_CLK_VAL); // R11
            end
            PROF_EXTTRIG: begin
                unique case (step)
                    4'h0: entry = ent(1'b0, 1'b0, IRQ_PIN1_MAP_ADDR, MAP_DATA_READY_VAL);
                    4'h1: entry = ent(1'b0, 1'b0, GENERAL_ADDR, RATE_TRIG_4G_VAL); // R12
                    default: entry = ent(1'b1, 1'b1, POWER_CTRL_ADDR, PWR_RUN_STATE_FIELD_VAL);
                endcase
            end
        endcase
    end
endmodule // acs_seq_rom

// ---- logic/acs_sequencer.sv ----
// host-side start-up sequencer and pin handler for the accelerometer
// Summary of operation
// R1: write thresholds, timers, motion control, queue, maps, settings, then power control; no profile writes queue control
// R2: measurement entered by writing run-state field value 10 into power control
// R3: activity duration programmed above 1 to reject brief spikes
// R4: after starting measurement wait 100 ms before data counts as valid
// R5: 0x40 in second map routes awake state to second pin
// R6: 0x01 in first map routes data ready to first pin
// R7: 0x3f in motion control enables referenced activity, inactivity and loop
// R8: 0x04 in motion control enables absolute inactivity detection
// R9: 0x20 in either map routes inactivity to that pin
// R10: loop switch loads provisional thresholds, then final ones after start
// R11: bit 6 of power control in standby makes first pin a clock input
// R12: bit 3 of range control makes second pin a per-sample trigger
// R13: 0x6b in range control enables trigger, 4 g range, 100 Hz
// R14: 0x83 in general settings selects 8 g range and 100 Hz
// R15: free fall sets inactivity status and raises inactivity on mapped pin
// R16: inactivity time is seconds times output sample rate
// R17: inactivity threshold is g times scale factor, 300 to 600 mg
// R18: free fall at 100 Hz writes 0x03 to upper inactivity time
`timescale 1ns/1ps
module acs_sequencer import acs_pkg::*; #(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int CLK_HALF   = EXT_CLK_HALF_CYCLES,
    parameter int TRIG_HIGH  = TRIG_HIGH_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire acs_profile_t profile,
    input  wire logic         stillOnSecond,
    input  wire logic         sampleReq,
    output logic              busy,
    output logic              dataValid,
    output logic              awake,
    output logic              stillEvent,
    output logic              dataReadyEvent,
    output logic              regWrValid,
    output logic [7:0]        regWrAddr,
    output logic [7:0]        regWrData,
    input  wire logic         regWrReady,
    input  wire logic         irqPinFirstIn,
    output logic              irqPinFirstOut,
    output logic              irqPinFirstOe,
    input  wire logic         irqPinSecondIn,
    output logic              irqPinSecondOut,
    output logic              irqPinSecondOe
);
    localparam int CNT_W = $clog2(SETTLE_CNT + 1);

    acs_state_t        state_q, state_d;
    acs_profile_t      prof_q, prof_d;
    logic              sec_q, sec_d;
    logic [STEP_W-1:0] step_q, step_d;
    logic [ENTRY_W-1:0] entry;
    logic              valid_q, valid_d;
    logic [7:0]        addr_q, addr_d, data_q, data_d;
    logic              last_q, last_d, settle_q, settle_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              dv_q, dv_d;
    logic              busy_q, busy_d;
    logic              accept;

    assign accept = valid_q && regWrReady;

    acs_seq_rom u_rom (
        .profile       (prof_d),
        .stillOnSecond (sec_d),
        .step          (step_d),
        .entry         (entry)
    );

    always_comb begin
        state_d  = state_q;
        prof_d   = prof_q;
        sec_d    = sec_q;
        step_d   = step_q;
        valid_d  = valid_q;
        cnt_d    = cnt_q;
        dv_d     = dv_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    prof_d  = profile;
                    sec_d   = stillOnSecond;
                    step_d  = '0;
                    valid_d = 1'b1;
                    state_d = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                // table order is register-map order up to the power control write, one write at a time
                if (accept) begin // R1
                    if (settle_q) begin
                        valid_d = 1'b0;
                        cnt_d   = CNT_W'(SETTLE_CNT);
                        state_d = ST_SETTLE;
                    end else if (last_q) begin
                        valid_d = 1'b0;
                        state_d = ST_RUN;
                    end else begin
                        step_d  = step_q + 1'b1;
                    end
                end
            end
            ST_SETTLE: begin
                if (cnt_q == CNT_W'(1)) begin // R4
                    dv_d = 1'b1;
                    if (last_q) begin
                        state_d = ST_RUN;
                    end else begin
                        // final thresholds only once the settle count has run out
                        step_d  = step_q + 1'b1; // R10
                        valid_d = 1'b1;
                        state_d = ST_ISSUE;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_RUN: begin
                if (start) begin
                    prof_d  = profile;
                    sec_d   = stillOnSecond;
                    step_d  = '0;
                    valid_d = 1'b1;
                    dv_d    = 1'b0;
                    state_d = ST_ISSUE;
                end
            end
        endcase
        // registered so the port comes straight from a flop
        busy_d = valid_d || state_d == ST_SETTLE;
    end

    // next write fields follow the table entry for the next step
    always_comb begin
        addr_d   = addr_q;
        data_d   = data_q;
        last_d   = last_q;
        settle_d = settle_q;
        if (valid_d && (step_d != step_q || state_q != ST_ISSUE)) begin
            {last_d, settle_d, addr_d, data_d} = entry;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            prof_q   <= PROF_MOTION;
            sec_q    <= 1'b0;
            step_q   <= '0;
            valid_q  <= 1'b0;
            addr_q   <= 8'h00;
            data_q   <= 8'h00;
            last_q   <= 1'b0;
            settle_q <= 1'b0;
            cnt_q    <= '0;
            dv_q     <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            prof_q   <= prof_d;
            sec_q    <= sec_d;
            step_q   <= step_d;
            valid_q  <= valid_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            last_q   <= last_d;
            settle_q <= settle_d;
            cnt_q    <= cnt_d;
            dv_q     <= dv_d;
            busy_q   <= busy_d;
        end
    end

    // device pins
    logic p1Level, p1Rise, p2Level, p2Rise;

    acs_pin_sync u_sync1 (
        .clk   (clk),
        .rst   (rst),
        .pinIn (irqPinFirstIn),
        .level (p1Level),
        .rise  (p1Rise)
    );

    acs_pin_sync u_sync2 (
        .clk   (clk),
        .rst   (rst),
        .pinIn (irqPinSecondIn),
        .level (p2Level),
        .rise  (p2Rise)
    );

    logic clkOn_q, clkOn_d, clkOut_q, clkOut_d;
    logic trigOn_q, trigOn_d, trigOut_q, trigOut_d;
    logic [7:0] div_q, div_d, tcnt_q, tcnt_d;
    logic awake_q, awake_d, still_q, still_d, dr_q, dr_d;
    logic isPwr, isRange;

    assign isPwr   = accept && addr_q == POWER_CTRL_ADDR;
    assign isRange = accept && addr_q == GENERAL_ADDR;

    always_comb begin
        clkOn_d   = clkOn_q;
        clkOut_d  = clkOut_q;
        div_d     = div_q;
        trigOn_d  = trigOn_q;
        trigOut_d = trigOut_q;
        tcnt_d    = tcnt_q;
        // the clock must run from the moment the switch-over write lands
        if (isPwr && data_q[EXT_CLK_BIT]) begin // R11
            clkOn_d = 1'b1;
        end
        if (clkOn_q) begin
            if (div_q == 8'(CLK_HALF - 1)) begin
                div_d    = 8'h00;
                clkOut_d = ~clkOut_q;
            end else begin
                div_d = div_q + 8'h01;
            end
        end
        if (isRange && data_q[EXT_TRIG_BIT]) begin // R12
            trigOn_d = 1'b1;
        end
        // one pulse per request; requests during a pulse are dropped
        if (tcnt_q != 8'h00) begin
            tcnt_d = tcnt_q - 8'h01;
            if (tcnt_q == 8'h01) begin
                trigOut_d = 1'b0;
            end
        end else if (trigOn_q && sampleReq) begin // R12
            trigOut_d = 1'b1;
            tcnt_d    = 8'(TRIG_HIGH);
        end
        if (state_q == ST_IDLE || (state_q == ST_RUN && start)) begin
            clkOn_d   = 1'b0;
            clkOut_d  = 1'b0;
            div_d     = 8'h00;
            trigOn_d  = 1'b0;
            trigOut_d = 1'b0;
            tcnt_d    = 8'h00;
        end
    end

    // pin meaning follows the map written by the active profile
    always_comb begin
        awake_d = (prof_q == PROF_MOTION) && dv_q && p2Level; // R5
        still_d = (prof_q == PROF_FREEFALL) && dv_q &&
                  (sec_q ? p2Rise : p1Rise); // R15
        dr_d    = (prof_q == PROF_MOTION || prof_q == PROF_EXTTRIG) && dv_q && p1Rise; // R6
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clkOn_q   <= 1'b0;
            clkOut_q  <= 1'b0;
            div_q     <= 8'h00;
            trigOn_q  <= 1'b0;
            trigOut_q <= 1'b0;
            tcnt_q    <= 8'h00;
            awake_q   <= 1'b0;
            still_q   <= 1'b0;
            dr_q      <= 1'b0;
        end else begin
            clkOn_q   <= clkOn_d;
            clkOut_q  <= clkOut_d;
            div_q     <= div_d;
            trigOn_q  <= trigOn_d;
            trigOut_q <= trigOut_d;
            tcnt_q    <= tcnt_d;
            awake_q   <= awake_d;
            still_q   <= still_d;
            dr_q      <= dr_d;
        end
    end

    assign busy            = busy_q;
    assign dataValid       = dv_q;
    assign awake           = awake_q;
    assign stillEvent      = still_q;
    assign dataReadyEvent  = dr_q;
    assign regWrValid      = valid_q;
    assign regWrAddr       = addr_q;
    assign regWrData       = data_q;
    assign irqPinFirstOut  = clkOut_q;
    assign irqPinFirstOe   = clkOn_q;
    assign irqPinSecondOut = trigOut_q;
    assign irqPinSecondOe  = trigOn_q;

    // checks
    sequence s_pwrMeasure;
        accept && addr_q == POWER_CTRL_ADDR;
    endsequence

    a_write_order: assert property (@(posedge clk) disable iff (rst) // R1
        accept && !settle_q && !last_q && state_q == ST_ISSUE && prof_q != PROF_MOTION
        |=> !valid_q || addr_q >= $past(addr_q))
        else $error("register writes out of map order");
    a_run_state_field_field: assert property (@(posedge clk) disable iff (rst) // R2
        s_pwrMeasure |-> data_q[RUN_STATE_LSB +: 2] == RUN_STATE_RUN_STATE_FIELD)
        else $error("power control written without measurement field");
    a_act_duration: assert property (@(posedge clk) disable iff (rst) // R3
        accept && addr_q == ACT_DURATION_ADDR |-> data_q > 8'h01)
        else $error("activity duration not above one");
    a_settle_wait: assert property (@(posedge clk) disable iff (rst) // R4
        s_pwrMeasure ##1 state_q == ST_SETTLE |-> !dv_q [*8])
        else $error("data marked valid before settling");
    a_loop_phase: assert property (@(posedge clk) disable iff (rst) // R10
        accept && prof_q == PROF_MOTION && step_q > 4'h8 |-> dv_q)
        else $error("final thresholds written before settling");
    a_clk_standby: assert property (@(posedge clk) disable iff (rst) // R11
        $rose(clkOn_q) |-> $past(isPwr) && $past(data_q) == PWR_EXT_CLK_VAL)
        else $error("clock driven without switch-over write");
    a_trig_pulse: assert property (@(posedge clk) disable iff (rst) // R12
        $rose(trigOut_q) |-> trigOut_q [*4] ##1 !trigOut_q)
        else $error("trigger pulse width wrong");
    a_fall_time: assert property (@(posedge clk) disable iff (rst) // R18
        accept && addr_q == STILL_TIME_UP_ADDR |-> data_q == FALL_TIME_UP_VAL)
        else $error("free fall time not 0x03");
endmodule // acs_sequencer

// ---- tb/acs_dev_model.sv ----
// behavioural accelerometer: register file, interrupt routing, pin timing
`timescale 1ns/1ps
module acs_dev_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        awakeIn,
    input  wire logic        stillIn,
    input  wire logic        drdyIn,
    input  wire logic        regWrValid,
    input  wire logic [7:0]  regWrAddr,
    input  wire logic [7:0]  regWrData,
    output logic             regWrReady,
    input  wire logic        irqPinFirstOut,
    input  wire logic        irqPinFirstOe,
    input  wire logic        irqPinSecondOut,
    input  wire logic        irqPinSecondOe,
    output logic             pinFirst,
    output logic             pinSecond,
    output logic [15:0]      clkEdges
);
    logic [7:0] regs [8'h20:8'h2d];
    logic [2:0] drdyCnt;
    logic       tog;
    logic       pin1Q;
    logic       pin2Q;
    logic       meas;
    logic       drdy;
    logic       irqOne;
    logic       irqTwo;
    assign meas = regs[8'h2d][1:0] == 2'h2;
    assign drdy = drdyCnt != 3'h0;
    assign irqOne = meas & (regs[8'h2a][0] & drdy | regs[8'h2a][5] & stillIn
                  | regs[8'h2a][6] & awakeIn);
    assign irqTwo = meas & (regs[8'h2b][0] & drdy | regs[8'h2b][5] & stillIn
                  | regs[8'h2b][6] & awakeIn);
    // slow mode accepts only every other cycle to stretch each write
    assign regWrReady = !slow | tog;
    assign pinFirst = irqPinFirstOe ? irqPinFirstOut : irqOne;
    assign pinSecond = irqPinSecondOe ? irqPinSecondOut : irqTwo;
    always_ff @(posedge clk) begin
        tog <= rst ? 1'b0 : !tog;
        pin1Q <= pinFirst;
        pin2Q <= pinSecond;
        if (rst) begin
            for (int i = 8'h20; i <= 8'h2d; i++) regs[i] <= 8'h00;
            drdyCnt <= 3'h0;
            clkEdges <= 16'h0000;
        end else begin
            if (regWrValid && regWrReady) regs[regWrAddr] <= regWrData;
            // one sample per trigger edge, flagged as data ready
            if (drdyIn || meas && regs[8'h2c][3] && pinSecond && !pin2Q) begin
                drdyCnt <= 3'h4;
            end else if (drdy) begin
                drdyCnt <= drdyCnt - 3'h1;
            end
            if (regs[8'h2d][6] && pinFirst != pin1Q) clkEdges <= clkEdges + 16'h1;
        end
    end
endmodule // acs_dev_model

// ---- tb/acs_sequencer_tb.sv ----
// self-checking bench: start-up profiles, pin events, trigger and clock drive
`timescale 1ns/1ps
module acs_sequencer_tb;
    import acs_pkg::*;
    localparam int SETTLE = 20;
    logic clk, rst, start, stillOnSecond, sampleReq, busy, dataValid, awake;
    logic stillEvent, dataReadyEvent, regWrValid, regWrReady, slow, awakeIn;
    logic stillIn, drdyIn, p1Out, p1Oe, p2Out, p2Oe, pin1, pin2;
    logic [7:0]  regWrAddr, regWrData;
    logic [15:0] clkEdges, e0;
    logic [15:0] wrLog[$];
    acs_profile_t profile;
    int n_errors, checked, cyc, pwrCyc, dvCyc, nStill, nDrdy, s0;
    logic dvPrev;
    acs_sequencer #(.SETTLE_CNT(SETTLE), .CLK_HALF(8), .TRIG_HIGH(4)) i_acs_sequencer (
        .clk(clk), .rst(rst), .start(start), .profile(profile),
        .stillOnSecond(stillOnSecond), .sampleReq(sampleReq), .busy(busy),
        .dataValid(dataValid), .awake(awake), .stillEvent(stillEvent),
        .dataReadyEvent(dataReadyEvent), .regWrValid(regWrValid), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .regWrReady(regWrReady), .irqPinFirstIn(pin1),
        .irqPinFirstOut(p1Out), .irqPinFirstOe(p1Oe), .irqPinSecondIn(pin2),
        .irqPinSecondOut(p2Out), .irqPinSecondOe(p2Oe));
    acs_dev_model i_acs_dev_model (
        .clk(clk), .rst(rst), .slow(slow), .awakeIn(awakeIn), .stillIn(stillIn),
        .drdyIn(drdyIn), .regWrValid(regWrValid), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .regWrReady(regWrReady), .irqPinFirstOut(p1Out),
        .irqPinFirstOe(p1Oe), .irqPinSecondOut(p2Out), .irqPinSecondOe(p2Oe),
        .pinFirst(pin1), .pinSecond(pin2), .clkEdges(clkEdges));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (regWrValid && regWrReady) wrLog.push_back({regWrAddr, regWrData});
        if (regWrValid && regWrReady && regWrAddr == 8'h2d) pwrCyc = cyc;
        if (dataValid === 1'b1 && dvPrev !== 1'b1) dvCyc = cyc;
        dvPrev = dataValid;
        if (stillEvent === 1'b1) nStill++;
        if (dataReadyEvent === 1'b1) nDrdy++;
    end
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic waitn(int n);
        repeat (n) @(negedge clk);
    endtask
    // poke tries a second start mid-sequence, which must be ignored
    task automatic run(acs_profile_t p, logic s2, logic poke, logic [15:0] seq[$]);
        int n;
        wrLog = {};
        @(posedge clk);
        start <= 1'b1;
        profile <= p;
        stillOnSecond <= s2;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        start <= poke;
        profile <= PROF_EXTCLK;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        waitn(2);
        chk("writes", 16'(wrLog.size()), 16'(seq.size()));
        foreach (seq[i]) chk("write", wrLog[i], seq[i]);
        chk("settle", 16'(dvCyc - pwrCyc >= SETTLE && dvCyc - pwrCyc <= SETTLE + 2), 1);
        chk("valid", 16'(dataValid), 1);
    endtask
    // one-cycle pulse on the trigger request (1) or the model's data-ready source (0)
    task automatic pulse(bit trig);
        @(posedge clk);
        if (trig) sampleReq <= 1'b1;
        else drdyIn <= 1'b1;
        @(posedge clk);
        sampleReq <= 1'b0;
        drdyIn <= 1'b0;
    endtask
    // mid-run reset: clears both the sequencer and the model's registers
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        start = 1'b0;
        profile = PROF_MOTION;
        stillOnSecond = 1'b0;
        sampleReq = 1'b0;
        slow = 1'b1;
        awakeIn = 1'b0;
        stillIn = 1'b0;
        drdyIn = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        run(PROF_MOTION, 1'b0, 1'b1, '{16'h20a0, 16'h210f, 16'h2202, 16'h2360, 16'h2409,
            16'h273f, 16'h2a01, 16'h2b40, 16'h2d02, 16'h200f, 16'h21a0, 16'h230a, 16'h24f0});
        @(posedge clk);
        awakeIn <= 1'b1;
        waitn(6);
        chk("awake", 16'(awake), 1);
        awakeIn <= 1'b0;
        waitn(6);
        chk("asleep", 16'(awake), 0);
        s0 = nDrdy;
        pulse(1'b0);
        waitn(10);
        chk("drdy", 16'(nDrdy - s0), 1);
        slow <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            // fresh device each pass, so only the chosen pin carries inactivity
            do_reset();
            run(PROF_FREEFALL, s[0], 1'b0, '{16'h2309, 16'h2418, 16'h2603, 16'h2704,
                s ? 16'h2b20 : 16'h2a20, 16'h2c83, 16'h2d02});
            s0 = nStill;
            stillIn <= 1'b1;
            waitn(10);
            chk("still", 16'(nStill - s0), 1);
            stillIn <= 1'b0;
            waitn(4);
        end
        // the clock switch needs the device back in standby
        do_reset();
        run(PROF_EXTCLK, 1'b0, 1'b0, '{16'h2d42});
        chk("clkOe", 16'(p1Oe), 1);
        e0 = clkEdges;
        waitn(64);
        chk("clkEdges", clkEdges - e0, 16'h0008);
        run(PROF_EXTTRIG, 1'b0, 1'b0, '{16'h2a01, 16'h2c6b, 16'h2d02});
        chk("clkOff", 16'(p1Oe), 0);
        chk("trigOe", 16'(p2Oe), 1);
        s0 = nDrdy;
        for (int k = 0; k < 3; k++) begin
            pulse(1'b1);
            waitn(20);
        end
        // a second request while the pulse stands is dropped
        @(posedge clk);
        sampleReq <= 1'b1;
        repeat (2) @(posedge clk);
        sampleReq <= 1'b0;
        waitn(20);
        chk("samples", 16'(nDrdy - s0), 4);
        end_of_test();
    end
endmodule // acs_sequencer_tb
